/* logic/sec_regs.svh */
// Constants of the serial memory command front end
// Notes on behaviour
// - First byte after select is the opcode
// - Six opcodes; latch set 06, clear 04
// - Status read 05, status write 01
// - Memory read 0000X011, write 0000X010
// - Opcode bit 3 carries A8 or zero
// - Input sampled on serial clock rise
// - Output changes on serial clock fall
// - Select high: output released, standby
// - Select must fall before every command
// - Write starts on select rise only
// - Write done within 10 ms or 5 ms
// - Protect pin high: no hardware protection
// - Pin low and enable bit: refuse status write
// - Pin fall during status write abandons it when the enable bit is set
// - Pin fall after start leaves write alone
// - Master waits 1 ms after power-up
// - Status bit 0 is busy, read only
// - Latch flag set by command, cleared by command or write start
// - Status read while busy returns high
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH
`define SEC_OP_LATCH_SET    8'h06
`define SEC_OP_LATCH_CLEAR  8'h04
`define SEC_OP_STATUS_READ  8'h05
`define SEC_OP_STATUS_WRITE 8'h01
`define SEC_OP_MEM_READ     3'h3
`define SEC_OP_MEM_WRITE    3'h2
`define SEC_OP_A8_BIT       3
`define SEC_ST_BUSY         0
`define SEC_ST_LATCH        1
`define SEC_ST_ENABLE       7
`define SEC_ST_ONES         8'h60
`define SEC_ST_USER_MASK    8'h9C
`define SEC_WRITE_MS        10
`define SEC_POWERUP_MS      1
`define SEC_CLK_KHZ         40000
`define SEC_DIV_HALF        8'h05
`endif

/* logic/sec_pkg.sv */
// Types shared by both ends of the serial memory link
package sec_pkg;
  typedef logic [7:0] sec_byte_t;
  typedef enum logic [1:0]
  {
    SEC_IDLE = 2'b00,
    SEC_OPC  = 2'b01,
    SEC_BODY = 2'b10,
    SEC_DEAD = 2'b11
  } sec_phase_e;
  typedef enum logic [1:0]
  {
    SEC_M_IDLE = 2'b00,
    SEC_M_WAIT = 2'b01,
    SEC_M_SHIFT = 2'b10,
    SEC_M_END  = 2'b11
  } sec_mstate_e;
endpackage

/* logic/sec_link_if.sv */
// Link wires between the serial master and the memory front end
`timescale 1ns/1ps
interface sec_link_if;
  logic sel_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic wp_n;
  modport dev
  (
    input  sel_n, sclk, sdi, wp_n,
    output sdo, sdo_oe_n
  );
  modport host
  (
    output sel_n, sclk, sdi, wp_n,
    input  sdo, sdo_oe_n
  );
endinterface

/* logic/sec_device.sv */
// Memory end: command decode, status register, timed write
`timescale 1ns/1ps
`include "sec_regs.svh"
module sec_device #(
  parameter int WRITE_CYCLES = `SEC_WRITE_MS * `SEC_CLK_KHZ
)(
  // Clock and reset
  input  wire logic REF_CLK,
  input  wire logic RESETN,
  input  wire logic CE,
  // Link
  sec_link_if.dev   LINK,
  // User side
  output logic      BUSY,
  output logic      WRITE_START,
  output sec_pkg::sec_byte_t OPCODE,
  output sec_pkg::sec_byte_t STATUS
);
  import sec_pkg::*;
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] sel_s, clk_s, di_s, wp_s;
  logic       clk_d;
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
    begin
      sel_s <= 2'h3;
      clk_s <= 2'h0;
      di_s  <= 2'h0;
      wp_s  <= 2'h3;
      clk_d <= 1'b0;
    end
    else if (CE)
    begin
      sel_s <= {sel_s[0], LINK.sel_n};
      clk_s <= {clk_s[0], LINK.sclk};
      di_s  <= {di_s[0], LINK.sdi};
      wp_s  <= {wp_s[0], LINK.wp_n};
      clk_d <= clk_s[1];
    end
  logic sel, rise, fall, sel_d;
  assign sel  = !sel_s[1];
  assign rise = sel && clk_s[1] && !clk_d;
  assign fall = sel && !clk_s[1] && clk_d;
  // ****************************************
  // Command shifter
  // ****************************************
  sec_phase_e phase_reg;
  logic [2:0] bit_reg;
  sec_byte_t  sh_reg, op_reg, stat_reg, new_stat_reg;
  logic [3:0] nbytes_reg;
  logic       wr_pend_reg, sr_pend_reg, busy_reg;
  sec_byte_t  sh_next;
  assign sh_next = {sh_reg[6:0], di_s[1]};
  logic is_mem_wr;
  assign is_mem_wr = sh_next[7:4] == 4'h0 &&
    sh_next[2:0] == `SEC_OP_MEM_WRITE;
  logic is_mem_rd;
  assign is_mem_rd = op_reg[7:4] == 4'h0 &&
    op_reg[2:0] == `SEC_OP_MEM_READ;
  logic is_mem_wr_op;
  assign is_mem_wr_op = op_reg[7:4] == 4'h0 &&
    op_reg[2:0] == `SEC_OP_MEM_WRITE;
  logic sr_lock;
  assign sr_lock = !wp_s[1] && stat_reg[`SEC_ST_ENABLE];
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
    begin
      phase_reg   <= SEC_IDLE;
      bit_reg     <= 3'h0;
      sh_reg      <= 8'h00;
      op_reg      <= 8'h00;
      nbytes_reg  <= 4'h0;
      wr_pend_reg <= 1'b0;
      sr_pend_reg <= 1'b0;
      new_stat_reg <= 8'h00;
      sel_d       <= 1'b0;
    end
    else if (CE)
    begin
      sel_d <= sel;
      if (!sel)
      begin
        phase_reg   <= SEC_IDLE;
        wr_pend_reg <= 1'b0;
        sr_pend_reg <= 1'b0;
      end
      else if (!sel_d)
      begin
        phase_reg  <= SEC_OPC;
        bit_reg    <= 3'h0;
        nbytes_reg <= 4'h0;
      end
      else if (rise && phase_reg != SEC_IDLE && phase_reg != SEC_DEAD)
      begin
        sh_reg  <= sh_next;
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'h7)
        begin
          if (phase_reg == SEC_OPC)
          begin
            op_reg    <= sh_next;
            phase_reg <= SEC_BODY;
            unique case (sh_next)
              `SEC_OP_LATCH_SET, `SEC_OP_LATCH_CLEAR,
              `SEC_OP_STATUS_READ, `SEC_OP_STATUS_WRITE: ;
              default:
                if (!is_mem_wr && !(sh_next[7:4] == 4'h0 &&
                    sh_next[2:0] == `SEC_OP_MEM_READ))
                  phase_reg <= SEC_DEAD;
            endcase
          end
          else
          begin
            if (nbytes_reg != 4'hF)
              nbytes_reg <= nbytes_reg + 4'h1;
            if (op_reg == `SEC_OP_STATUS_WRITE && nbytes_reg == 4'h0
                && stat_reg[`SEC_ST_LATCH] && !busy_reg && !sr_lock)
            begin
              sr_pend_reg  <= 1'b1;
              new_stat_reg <= sh_next;
            end
            if (is_mem_wr_op && nbytes_reg != 4'h0
                && stat_reg[`SEC_ST_LATCH] && !busy_reg)
              wr_pend_reg <= 1'b1;
          end
        end
      end
      if (sel && op_reg == `SEC_OP_STATUS_WRITE && wp_s[1] == 1'b0
          && stat_reg[`SEC_ST_ENABLE])
        sr_pend_reg <= 1'b0;
    end
  // ****************************************
  // Status register and timed write
  // ****************************************
  logic end_frame, start;
  assign end_frame = !sel && sel_d;
  assign start = end_frame && (wr_pend_reg || sr_pend_reg)
    && !busy_reg;
  logic [31:0] wcnt_reg;
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
    begin
      busy_reg    <= 1'b0;
      wcnt_reg    <= 32'h0;
      WRITE_START <= 1'b0;
    end
    else if (CE)
    begin
      WRITE_START <= start;
      if (start)
      begin
        busy_reg <= 1'b1;
        wcnt_reg <= 32'h0;
      end
      else if (busy_reg)
      begin
        wcnt_reg <= wcnt_reg + 32'h1;
        if (wcnt_reg == 32'(WRITE_CYCLES - 1))
          busy_reg <= 1'b0;
      end
    end
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
      stat_reg <= `SEC_ST_ONES;
    else if (CE)
    begin
      stat_reg[`SEC_ST_BUSY] <= busy_reg || start;
      if (start && sr_pend_reg)
        stat_reg <= (stat_reg & ~`SEC_ST_USER_MASK)
          | (new_stat_reg & `SEC_ST_USER_MASK) | 8'h01;
      if (start || (sel && phase_reg == SEC_OPC && rise
          && bit_reg == 3'h7 && sh_next == `SEC_OP_LATCH_CLEAR))
        stat_reg[`SEC_ST_LATCH] <= 1'b0;
      else if (sel && phase_reg == SEC_OPC && rise && bit_reg == 3'h7
          && sh_next == `SEC_OP_LATCH_SET)
        stat_reg[`SEC_ST_LATCH] <= 1'b1;
    end
  // ****************************************
  // Serial output
  // ****************************************
  logic [2:0] obit_reg;
  logic       talk;
  assign talk = phase_reg == SEC_BODY &&
    (op_reg == `SEC_OP_STATUS_READ || is_mem_rd);
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
    begin
      LINK.sdo      <= 1'b1;
      LINK.sdo_oe_n <= 1'b1;
      obit_reg      <= 3'h0;
    end
    else if (CE)
    begin
      if (!sel || !talk)
      begin
        LINK.sdo_oe_n <= 1'b1;
        obit_reg      <= 3'h0;
      end
      else if (fall)
      begin
        LINK.sdo_oe_n <= 1'b0;
        obit_reg      <= obit_reg + 3'h1;
        if (op_reg == `SEC_OP_STATUS_READ && !busy_reg)
          LINK.sdo <= stat_reg[3'h7 - obit_reg];
        else
          LINK.sdo <= 1'b1;
      end
    end
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
    begin
      BUSY   <= 1'b0;
      OPCODE <= 8'h00;
      STATUS <= `SEC_ST_ONES;
    end
    else if (CE)
    begin
      BUSY   <= busy_reg;
      OPCODE <= op_reg;
      STATUS <= stat_reg;
    end
endmodule

/* logic/sec_host.sv */
// Master end: runs one framed byte transfer per request
`timescale 1ns/1ps
`include "sec_regs.svh"
module sec_host #(
  parameter int NBYTES_MAX = 4,
  parameter int POWERUP_CYCLES = `SEC_POWERUP_MS * `SEC_CLK_KHZ
)(
  // Clock and reset
  input  wire logic REF_CLK,
  input  wire logic RESETN,
  input  wire logic CE,
  // Link
  sec_link_if.host  LINK,
  // Command port
  input  wire logic [1:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA
);
  import sec_pkg::*;
  // ****************************************
  // Registers: 0 tx bytes, 1 control, 2 rx, 3 status
  // ****************************************
  sec_mstate_e st_reg;
  logic [31:0] tx_reg, rx_reg;
  logic [2:0]  len_reg, bcnt_reg, bit_reg;
  logic        wp_reg, go;
  logic [31:0] pu_reg;
  logic        sdo_s0, sdo_s1;
  logic [7:0]  div_reg;
  assign go = WR && ADDR == 2'h1 && WDATA[2:0] != 3'h0
    && 32'(WDATA[2:0]) <= 32'(NBYTES_MAX) && st_reg == SEC_M_IDLE;
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
    begin
      RDATA  <= 32'h0;
      wp_reg <= 1'b1;
    end
    else if (CE)
    begin
      if (WR && ADDR == 2'h1)
        wp_reg <= WDATA[8];
      unique case (ADDR)
        2'h0: RDATA <= tx_reg;
        2'h1: RDATA <= {23'h0, wp_reg, 5'h0, len_reg};
        2'h2: RDATA <= rx_reg;
        2'h3: RDATA <= {30'h0, pu_reg != 32'h0, st_reg != SEC_M_IDLE};
      endcase
      if (!RD)
        RDATA <= 32'h0;
    end
  // ****************************************
  // Frame engine, mode 0 clock by divider
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
    begin
      st_reg        <= SEC_M_IDLE;
      LINK.sel_n    <= 1'b1;
      LINK.sclk     <= 1'b0;
      LINK.sdi      <= 1'b0;
      LINK.wp_n     <= 1'b1;
      len_reg       <= 3'h0;
      bcnt_reg      <= 3'h0;
      bit_reg       <= 3'h0;
      div_reg       <= 8'h0;
      rx_reg        <= 32'h0;
      tx_reg        <= 32'h0;
      pu_reg        <= 32'(POWERUP_CYCLES);
      sdo_s0        <= 1'b1;
      sdo_s1        <= 1'b1;
    end
    else if (CE)
    begin
      sdo_s0    <= LINK.sdo;
      sdo_s1    <= sdo_s0;
      LINK.wp_n <= wp_reg;
      if (WR && ADDR == 2'h0)
        tx_reg <= WDATA;
      if (pu_reg != 32'h0)
        pu_reg <= pu_reg - 32'h1;
      unique case (st_reg)
        SEC_M_IDLE:
          if (go && pu_reg == 32'h0)
          begin
            len_reg    <= WDATA[2:0];
            LINK.sel_n <= 1'b0;
            LINK.sdi   <= tx_reg[31];
            bcnt_reg   <= 3'h0;
            bit_reg    <= 3'h0;
            div_reg    <= 8'h0;
            st_reg     <= SEC_M_WAIT;
          end
        SEC_M_WAIT:
          if (div_reg == `SEC_DIV_HALF)
          begin
            div_reg <= 8'h0;
            st_reg  <= SEC_M_SHIFT;
          end
          else
            div_reg <= div_reg + 8'h1;
        SEC_M_SHIFT:
          if (div_reg == `SEC_DIV_HALF)
          begin
            div_reg   <= 8'h0;
            LINK.sclk <= !LINK.sclk;
            if (!LINK.sclk)
              rx_reg <= {rx_reg[30:0], sdo_s1};
            else
            begin
              bit_reg <= bit_reg + 3'h1;
              tx_reg  <= {tx_reg[30:0], 1'b0};
              LINK.sdi <= tx_reg[30];
              if (bit_reg == 3'h7)
              begin
                bcnt_reg <= bcnt_reg + 3'h1;
                if (bcnt_reg + 3'h1 == len_reg)
                  st_reg <= SEC_M_END;
              end
            end
          end
          else
            div_reg <= div_reg + 8'h1;
        SEC_M_END:
          if (div_reg == `SEC_DIV_HALF)
          begin
            LINK.sel_n <= 1'b1;
            st_reg     <= SEC_M_IDLE;
          end
          else
            div_reg <= div_reg + 8'h1;
      endcase
    end
endmodule

/* test/sec_link_asserts.sv */
// Checker on the link wires and the memory end outputs
`timescale 1ns/1ps
`include "sec_regs.svh"
module sec_link_asserts #(
  parameter int WRITE_CYCLES = `SEC_WRITE_MS * `SEC_CLK_KHZ
)(
  // Clock and reset
  input wire logic               REF_CLK,
  input wire logic               RESETN,
  // Link
  input wire logic               sel_n,
  input wire logic               sclk,
  input wire logic               sdo,
  input wire logic               sdo_oe_n,
  input wire logic               wp_n,
  // Memory end outputs
  input wire logic               BUSY,
  input wire logic               WRITE_START,
  input wire sec_pkg::sec_byte_t OPCODE,
  input wire sec_pkg::sec_byte_t STATUS
);
  import sec_pkg::*;
  // ****
  // Properties
  // ****
  localparam int W_HI = WRITE_CYCLES + 8;
  // Length of the current busy stretch
  int busy_len;
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
      busy_len <= 0;
    else if (BUSY)
      busy_len <= busy_len + 1;
    else
      busy_len <= 0;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  AST_SEL_RELEASE: assert property (sel_n [*6] |-> sdo_oe_n)
    else $error("output driven while deselected");
  AST_SDO_ON_FALL: assert property (
    ($changed(sdo) && !sdo_oe_n) |-> !sclk)
    else $error("output changed outside clock low");
  AST_START_DESEL: assert property (WRITE_START |-> sel_n)
    else $error("write started while selected");
  AST_START_BUSY: assert property (WRITE_START |-> ##[0:2] BUSY)
    else $error("write start without busy");
  AST_WRITE_TIME: assert property (busy_len <= W_HI)
    else $error("internal write too long");
  AST_BUSY_BIT: assert property ((BUSY != STATUS[0]) |=>
    (BUSY == STATUS[0]))
    else $error("busy bit does not follow busy");
  AST_NO_RESTART: assert property (
    ($past(BUSY) && BUSY) |-> !WRITE_START)
    else $error("write restarted while busy");
  AST_LATCH_BY_SET: assert property (
    $rose(STATUS[1]) |-> OPCODE == `SEC_OP_LATCH_SET)
    else $error("latch set by other opcode");
  AST_STATUS_WP: assert property (
    (WRITE_START && OPCODE == `SEC_OP_STATUS_WRITE)
    |-> (wp_n || !STATUS[`SEC_ST_ENABLE]))
    else $error("status write while protected");
  AST_OUT_READS: assert property (!sdo_oe_n |->
    (OPCODE == `SEC_OP_STATUS_READ || (OPCODE[7:4] == 4'h0
    && OPCODE[2:0] == `SEC_OP_MEM_READ)))
    else $error("output driven for non-read opcode");
  AST_OPC_SELECTED: assert property ($changed(OPCODE) |-> !sel_n)
    else $error("opcode changed while deselected");
endmodule

/* test/tb_top.sv */
// Self-checking bench for both ends of the serial memory link
`timescale 1ns/1ps
`include "sec_regs.svh"
module tb_top;
  import sec_pkg::*;
  // ****
  // Harness
  // ****
  localparam int WCYC = 900;
  logic        REF_CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic [1:0]  ADDR = 2'h0;
  logic [31:0] WDATA = 32'h0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [31:0] RDATA;
  logic        BUSY;
  logic        WRITE_START;
  sec_byte_t   OPCODE;
  sec_byte_t   STATUS;
  logic [31:0] rd_val;
  int          err_total = 0;
  int          n_compared = 0;
  sec_link_if link_if ();
  always #12.5 REF_CLK = ~REF_CLK;
  sec_device #(.WRITE_CYCLES(WCYC)) sec_device_inst (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .CE(1'b1), .LINK(link_if.dev),
    .BUSY(BUSY), .WRITE_START(WRITE_START), .OPCODE(OPCODE),
    .STATUS(STATUS));
  sec_host #(.NBYTES_MAX(4), .POWERUP_CYCLES(10)) sec_host_inst (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .CE(1'b1), .LINK(link_if.host),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  sec_link_asserts #(.WRITE_CYCLES(WCYC)) sec_link_asserts_inst (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .sel_n(link_if.sel_n),
    .sclk(link_if.sclk), .sdo(link_if.sdo), .sdo_oe_n(link_if.sdo_oe_n),
    .wp_n(link_if.wp_n), .BUSY(BUSY), .WRITE_START(WRITE_START),
    .OPCODE(OPCODE), .STATUS(STATUS));
  // ****
  // Tasks
  // ****
  function automatic sec_byte_t st_exp(sec_byte_t d);
    return `SEC_ST_ONES | (d & `SEC_ST_USER_MASK);
  endfunction
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_up(int i);
    if (i == 3000)
    begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic reg_wr(logic [1:0] a, logic [31:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  task automatic reg_rd(logic [1:0] a);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 rd_val = RDATA;
  endtask
  task automatic wait_clear(logic [31:0] m);
    int i;
    rd_val = m;
    for (i = 0; i < 3000 && (rd_val & m) !== 32'h0; i++)
      reg_rd(2'h3);
    give_up(i);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000 && BUSY !== 1'b0; i++)
      @(posedge REF_CLK);
    give_up(i);
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask
  task automatic send(sec_byte_t b0, sec_byte_t b1, sec_byte_t b2,
                      logic [2:0] n, logic wp);
    reg_wr(2'h0, {b0, b1, b2, 8'h00});
    reg_wr(2'h1, {23'h0, wp, 5'h0, n});
    wait_clear(32'h1);
    repeat (6) @(posedge REF_CLK);
    #1;
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    int k;
    sec_byte_t d;
    void'($urandom(32'h6540));
    repeat (16) @(posedge REF_CLK);
    RESETN <= 1'b1;
    wait_clear(32'h2);
    check("status reset", 32'h60, 32'(STATUS));
    send(`SEC_OP_LATCH_SET, 8'h00, 8'h00, 3'h1, 1'b1);
    check("opcode", 32'h06, 32'(OPCODE));
    check("latch set", 32'h62, 32'(STATUS));
    send(`SEC_OP_LATCH_CLEAR, 8'h00, 8'h00, 3'h1, 1'b1);
    check("latch clear", 32'h60, 32'(STATUS));
    send(`SEC_OP_STATUS_WRITE, 8'h9C, 8'h00, 3'h2, 1'b1);
    check("no latch", 32'h60, 32'(STATUS));
    send(`SEC_OP_LATCH_SET, 8'h00, 8'h00, 3'h1, 1'b1);
    send(`SEC_OP_STATUS_WRITE, 8'h8C, 8'h00, 3'h2, 1'b1);
    wait_idle();
    check("status wr", 32'(st_exp(8'h8C)), 32'(STATUS));
    send(`SEC_OP_STATUS_READ, 8'h00, 8'h00, 3'h2, 1'b1);
    reg_rd(2'h2);
    check("status rd", 32'(st_exp(8'h8C)), rd_val & 32'hFF);
    send(`SEC_OP_LATCH_SET, 8'h00, 8'h00, 3'h1, 1'b1);
    send(`SEC_OP_STATUS_WRITE, 8'h00, 8'h00, 3'h2, 1'b0);
    wait_idle();
    check("wp refuse", 32'(st_exp(8'h8C) | 8'h02), 32'(STATUS));
    send(`SEC_OP_STATUS_WRITE, 8'h00, 8'h00, 3'h2, 1'b1);
    wait_idle();
    check("wp high", 32'h60, 32'(STATUS));
    send({1'b1, 3'($urandom), 4'h6}, 8'h00, 8'h00, 3'h2, 1'b1);
    check("unknown op", 32'h60, 32'(STATUS));
    send({4'h0, 1'b1, `SEC_OP_MEM_READ}, 8'h10, 8'h00, 3'h3, 1'b1);
    reg_rd(2'h2);
    check("mem read", 32'hFF, rd_val & 32'hFF);
    for (k = 0; k < 3; k++)
    begin
      d = 8'($urandom);
      send(`SEC_OP_LATCH_SET, 8'h00, 8'h00, 3'h1, 1'b1);
      send({4'h0, d[0], `SEC_OP_MEM_WRITE}, d, 8'($urandom), 3'h3, d[1]);
      check("write busy", 32'h1, 32'(BUSY));
      send(`SEC_OP_STATUS_READ, 8'h00, 8'h00, 3'h2, 1'b1);
      reg_rd(2'h2);
      check("busy read", 32'hFF, rd_val & 32'hFF);
      send(`SEC_OP_LATCH_SET, 8'h00, 8'h00, 3'h1, 1'b1);
      send({4'h0, 1'b0, `SEC_OP_MEM_WRITE}, d, 8'h00, 3'h3, 1'b1);
      wait_idle();
      repeat (8) @(posedge REF_CLK);
      check("no restart", 32'h0, 32'(BUSY));
      check("latch kept", 32'h62, 32'(STATUS));
    end
    finish_test();
  end
endmodule
